// ===== rtl/rhbd_pkg.sv
/*
 package for the half-bridge burst and dead-time sequencer: states, option codes, timing counts.
 assumes a 10 MHz system clock; all times are converted to cycles here.
*/
package rhbd_pkg;
	localparam int  CLK_HZ          = 10000000;
	localparam int  TW              = 16;
	localparam int  PRECHARGE_NS    = 2000;
	localparam int  DT_MAX_NS       = 1000;
	localparam int  AREC_US         = 1000;
	localparam int  PRECHARGE_CYC   = (PRECHARGE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int  DT_MAX_CYC      = (DT_MAX_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int  AREC_CYC        = AREC_US * (CLK_HZ / 1000000);
	localparam int  DT_FAULT_LIMIT  = 4;
	localparam int  SYNC_STAGES     = 3;

	typedef enum logic [1:0]
	{
		RHBD_FLT_IGNORE = 2'h0,
		RHBD_FLT_LATCH  = 2'h1,
		RHBD_FLT_AREC   = 2'h2
	} rhbd_fault_type;

	typedef enum logic [9:0]
	{
		ST_OFF      = 10'h001,
		ST_DISCH    = 10'h002,
		ST_HIGH     = 10'h004,
		ST_DT_HL    = 10'h008,
		ST_LOW      = 10'h010,
		ST_DT_LH    = 10'h020,
		ST_LASTLOW  = 10'h040,
		ST_IDLE     = 10'h080,
		ST_PRECH    = 10'h100,
		ST_FAULT    = 10'h200
	} rhbd_state_type;
endpackage

// ===== rtl/rhbd_sync.sv
/*
 three-flop input synchroniser; output changes once stages two and three agree.
 assumes the input is asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module rhbd_sync
(
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic din,
	output logic      dout
);
	logic [2:0] stage_q;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			stage_q <= 3'h0;
		else
			stage_q <= {stage_q[1:0], din};
	end

	// first stage is only read by the second
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			dout <= 1'b0;
		else if (stage_q[1] == stage_q[2])
			dout <= stage_q[2];
	end
endmodule
`default_nettype wire

// ===== rtl/rhbd_cnt.sv
/*
 event counter confirming a fault after a configured number of events.
 assumes pulses on evt are single-cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rhbd_cnt
#(
	parameter int W = 8
)
(
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic         clr,
	input  wire logic         evt,
	input  wire logic [W-1:0] limit,
	output logic              hit
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge mclk)
	begin
		if (!resetn || clr)
			cnt_q <= '0;
		else if (evt && cnt_q != limit)
			cnt_q <= cnt_q + 1'b1;
	end

	assign hit = evt && ((cnt_q + 1'b1) >= limit);
endmodule
`default_nettype wire

// ===== rtl/rhbd_core.sv
/*
 half-bridge resonant sequencer: normal symmetric switching, burst entry/exit,
 asymmetric low-side prolongation, on-time repetition, automatic dead time with clamp,
 midpoint discharge before start and thermal shutdown.
 assumes comparator flags arrive asynchronously and options are static straps.
*/
// Summary of operation
// - normal mode drives both switches with equal halves of the period
// - burst entry comparator is sampled only during high-side on-time
// - burst entry latches the current high-side on-time
// - after burst entry a final low pulse of 3/2 stored width, then stop
// - idle with blocks powered down until feedback exceeds exit level
// - burst restart begins with a low-side precharge pulse
// - after precharge and dead gap, high pulse ends on current trip
// - low pulse equals previous high width when on-time comparator already low
// - low pulse prolonged while on-time comparator stays high
// - prolongation repeats until symmetric, then disabled until the next precharge ends
// - burst exit checked each high period; then dead gap and 3/2 low pulse
// - high pulse ends at repeated last width if comparator stays high
// - opposite switch turns on after edge-sense reports completion or at the ceiling
// - no edge-sense within ceiling forces switch on and flags fault
// - fault reaction is ignore, latch off, or auto-recovery restart
// - with counter option, fault confirmed after limit events
// - fixed option ignores edge sense, uses ceiling, no faults
// - discharge switch on before start until midpoint reaches floor
// - high-side driver held off during bootstrap undervoltage
// - thermal trip stops switching, enters self-supply off mode, remembers until one cycle after the trip clears
// - thermal trip clearing starts a full restart with soft-start
// - first high pulse of each burst lowers internal feedback level
`timescale 1ns/1ps
`default_nettype none
module rhbd_core
#(
	parameter int TW        = rhbd_pkg::TW,
	parameter int PRE_CYC   = rhbd_pkg::PRECHARGE_CYC,
	parameter int DTMAX_CYC = rhbd_pkg::DT_MAX_CYC,
	parameter int AREC_CYC  = rhbd_pkg::AREC_CYC,
	parameter int FLT_LIMIT = rhbd_pkg::DT_FAULT_LIMIT
)
(
	input  wire logic                     mclk,
	input  wire logic                     resetn,
	input  wire logic                     startReq,
	input  wire logic                     burstEntryCmp,
	input  wire logic                     burstExitCmp,
	input  wire logic                     onTimeCmp,
	input  wire logic                     currentSenseTrip,
	input  wire logic                     edgeHighToLow,
	input  wire logic                     edgeLowToHigh,
	input  wire logic                     midpointAtFloor,
	input  wire logic                     bootstrapUvlo,
	input  wire logic                     thermalTrip,
	input  wire rhbd_pkg::rhbd_fault_type faultReactionCfg,
	input  wire logic                     faultCounterCfg,
	input  wire logic                     fixedDeadCfg,
	output logic                          highSideSwitch,
	output logic                          lowSideSwitch,
	output logic                          dischargeSwitch,
	output logic                          burstIdle,
	output logic                          feedbackReduce,
	output logic                          selfSupply,
	output logic                          thermalMemory,
	output logic                          softStartReq,
	output logic                          latchedOff,
	output logic                          deadFault
);
	import rhbd_pkg::*;

	rhbd_state_type state_q;
	logic [TW-1:0]  timer_q;
	logic [TW-1:0]  highWidth_q;
	logic [TW-1:0]  storedHighOnWidth_q;
	logic           inBurst_q;
	logic           asymEnable_q;
	logic           firstHigh_q;
	logic           exitPending_q;
	logic           entryPending_q;
	logic           thermal_q;
	logic           latched_q;
	logic           deadFault_q;
	logic           fltReact_q;
	logic           fltCountOn_q;
	logic           fixedDead_q;
	rhbd_fault_type fltSel_q;

	logic sEntry;
	logic sExit;
	logic sOnTime;
	logic sCs;
	logic sEdgeHl;
	logic sEdgeLh;
	logic sFloor;
	logic sUvlo;
	logic sTherm;

	rhbd_sync u_sEntry (.mclk(mclk), .resetn(resetn), .din(burstEntryCmp),    .dout(sEntry));
	rhbd_sync u_sExit  (.mclk(mclk), .resetn(resetn), .din(burstExitCmp),     .dout(sExit));
	rhbd_sync u_sOn    (.mclk(mclk), .resetn(resetn), .din(onTimeCmp),        .dout(sOnTime));
	rhbd_sync u_sCs    (.mclk(mclk), .resetn(resetn), .din(currentSenseTrip), .dout(sCs));
	rhbd_sync u_sHl    (.mclk(mclk), .resetn(resetn), .din(edgeHighToLow),    .dout(sEdgeHl));
	rhbd_sync u_sLh    (.mclk(mclk), .resetn(resetn), .din(edgeLowToHigh),    .dout(sEdgeLh));
	rhbd_sync u_sFl    (.mclk(mclk), .resetn(resetn), .din(midpointAtFloor),  .dout(sFloor));
	rhbd_sync u_sUv    (.mclk(mclk), .resetn(resetn), .din(bootstrapUvlo),    .dout(sUvlo));
	rhbd_sync u_sTh    (.mclk(mclk), .resetn(resetn), .din(thermalTrip),      .dout(sTherm));

	function automatic logic [TW-1:0] threeHalves(input logic [TW-1:0] w);
		threeHalves = w + (w >> 1);
	endfunction

	localparam logic [TW-1:0] PRE_T   = TW'(PRE_CYC);
	localparam logic [TW-1:0] DTMAX_T = TW'(DTMAX_CYC);
	localparam logic [TW-1:0] AREC_T  = TW'(AREC_CYC);
	localparam logic [TW-1:0] ONE_T   = TW'(1);

	// dead-gap completion and timeout
	logic inDead;
	logic edgeDone;
	logic dtTimeout;
	logic dtEvent;
	logic dtConfirm;
	logic dtHit;
	logic canHigh;

	assign inDead    = (state_q == ST_DT_HL) || (state_q == ST_DT_LH);
	assign edgeDone  = !fixedDead_q && ((state_q == ST_DT_HL) ? sEdgeHl : sEdgeLh);
	assign dtTimeout = inDead && (timer_q >= DTMAX_T);
	assign dtEvent   = dtTimeout && !edgeDone && !fixedDead_q;
	assign dtConfirm = dtEvent && (!fltCountOn_q || dtHit);
	assign canHigh   = !sUvlo;

	rhbd_cnt #(.W(8)) u_dtcnt
	(
		.mclk   (mclk),
		.resetn (resetn),
		.clr    (state_q == ST_OFF || state_q == ST_FAULT), // a recovered start counts afresh
		.evt    (dtEvent),
		.limit  (8'(FLT_LIMIT)),
		.hit    (dtHit)
	);

	// options are straps caught on the last clocked cycle of reset
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			fltSel_q     <= faultReactionCfg;
			fltCountOn_q <= faultCounterCfg;
			fixedDead_q  <= fixedDeadCfg;
		end
	end

	assign fltReact_q = (fltSel_q != RHBD_FLT_IGNORE);

	// thermal memory: set wins over clear
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			thermal_q <= 1'b0;
		else if (sTherm)
			thermal_q <= 1'b1;
		else if (state_q == ST_OFF && !sTherm)
			thermal_q <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			latched_q <= 1'b0;
		else if (dtConfirm && fltSel_q == RHBD_FLT_LATCH)
			latched_q <= 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			deadFault_q <= 1'b0;
		else if (dtConfirm)
			deadFault_q <= 1'b1;
		else if (state_q == ST_DISCH)
			deadFault_q <= 1'b0;
	end

	// main sequencer
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state_q             <= ST_OFF;
			timer_q             <= '0;
			highWidth_q         <= '0;
			storedHighOnWidth_q <= '0;
			inBurst_q           <= 1'b0;
			asymEnable_q        <= 1'b0;
			firstHigh_q         <= 1'b0;
			exitPending_q       <= 1'b0;
			entryPending_q      <= 1'b0;
		end
		else if (sTherm || latched_q)
		begin
			state_q <= ST_OFF;
			timer_q <= '0;
		end
		else
		begin
			timer_q <= timer_q + ONE_T;
			unique case (state_q)
				ST_OFF:
				begin
					timer_q <= '0;
					if (startReq)
						state_q <= ST_DISCH;
				end
				ST_DISCH:
				begin
					if (sFloor)
					begin
						state_q        <= ST_DT_LH;
						timer_q        <= '0;
						inBurst_q      <= 1'b0;
						highWidth_q    <= DTMAX_T;
						entryPending_q <= 1'b0;
					end
				end
				ST_HIGH:
				begin
					if (sEntry && !inBurst_q)
						entryPending_q <= 1'b1;
					if (sEntry && inBurst_q)
						exitPending_q <= 1'b1;
					if (!canHigh || sCs || (!sOnTime && !firstHigh_q)
						|| (!firstHigh_q && timer_q + ONE_T >= highWidth_q))
					begin
						state_q     <= ST_DT_HL;
						timer_q     <= '0;
						highWidth_q <= timer_q + ONE_T;
						firstHigh_q <= 1'b0;
						if (sEntry || entryPending_q || exitPending_q)
							storedHighOnWidth_q <= timer_q + ONE_T;
					end
				end
				ST_DT_HL:
				begin
					if (edgeDone || dtTimeout)
					begin
						timer_q <= '0;
						if (dtConfirm && fltReact_q)
							state_q <= ST_FAULT;
						else if (entryPending_q || exitPending_q)
							state_q <= ST_LASTLOW;
						else
							state_q <= ST_LOW;
					end
				end
				ST_LOW:
				begin
					if (timer_q + ONE_T >= highWidth_q && (!asymEnable_q || !sOnTime))
					begin
						state_q <= ST_DT_LH;
						timer_q <= '0;
						if (asymEnable_q && timer_q + ONE_T == highWidth_q)
							asymEnable_q <= 1'b0;
					end
				end
				ST_LASTLOW:
				begin
					if (timer_q + ONE_T >= threeHalves(storedHighOnWidth_q))
					begin
						state_q        <= ST_IDLE;
						timer_q        <= '0;
						entryPending_q <= 1'b0;
						exitPending_q  <= 1'b0;
						inBurst_q      <= 1'b0;
					end
				end
				ST_IDLE:
				begin
					timer_q <= '0;
					if (sExit)
						state_q <= ST_PRECH;
				end
				ST_PRECH:
				begin
					if (timer_q + ONE_T >= PRE_T)
					begin
						state_q      <= ST_DT_LH;
						timer_q      <= '0;
						inBurst_q    <= 1'b1;
						asymEnable_q <= 1'b1;
						firstHigh_q  <= 1'b1;
					end
				end
				ST_DT_LH:
				begin
					if ((edgeDone || dtTimeout) && canHigh)
					begin
						timer_q <= '0;
						if (dtConfirm && fltReact_q)
							state_q <= ST_FAULT;
						else
							state_q <= ST_HIGH;
					end
				end
				ST_FAULT:
				begin
					// auto-recovery waits out the delay then redischarges
					if (timer_q + ONE_T >= AREC_T)
					begin
						state_q <= ST_DISCH;
						timer_q <= '0;
					end
				end
				default:
					state_q <= ST_OFF;
			endcase
		end
	end

	// outputs registered; high side gated by bootstrap lockout
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			highSideSwitch  <= 1'b0;
			lowSideSwitch   <= 1'b0;
			dischargeSwitch <= 1'b0;
			burstIdle       <= 1'b0;
			feedbackReduce  <= 1'b0;
			selfSupply      <= 1'b0;
			softStartReq    <= 1'b0;
		end
		else
		begin
			highSideSwitch  <= (state_q == ST_HIGH) && canHigh && !sTherm;
			lowSideSwitch   <= (state_q == ST_LOW || state_q == ST_LASTLOW
				|| state_q == ST_PRECH) && !sTherm;
			dischargeSwitch <= (state_q == ST_DISCH);
			burstIdle       <= (state_q == ST_IDLE);
			feedbackReduce  <= (state_q == ST_HIGH) && firstHigh_q;
			selfSupply      <= thermal_q || latched_q || state_q == ST_FAULT;
			softStartReq    <= (state_q == ST_DISCH) && sFloor;
		end
	end

	assign thermalMemory = thermal_q;
	assign latchedOff    = latched_q;
	assign deadFault     = deadFault_q;
endmodule
`default_nettype wire

// ===== dv/rhbd_core_chk.sv
/*
 port-level assertions for rhbd_core.
 assumes the bind at the foot; straps change only while resetn is low.
*/
`timescale 1ns/1ps
`default_nettype none
module rhbd_core_chk
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic bootstrapUvlo,
	input wire logic thermalTrip,
	input wire logic fixedDeadCfg,
	input wire logic highSideSwitch,
	input wire logic lowSideSwitch,
	input wire logic dischargeSwitch,
	input wire logic burstIdle,
	input wire logic selfSupply,
	input wire logic softStartReq,
	input wire logic latchedOff,
	input wire logic deadFault
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	no_overlap_a: assert property (!(highSideSwitch && lowSideSwitch))
		else $error("both gates on");
	low_gap_a: assert property ($rose(lowSideSwitch) |-> !$past(highSideSwitch))
		else $error("low gate without dead gap");
	high_gap_a: assert property ($rose(highSideSwitch) |-> !$past(lowSideSwitch))
		else $error("high gate without dead gap");
	high_side_undervoltage_lockout_hold_a: assert property (bootstrapUvlo [*8] |-> !highSideSwitch)
		else $error("high gate during bootstrap lockout");
	thermal_stop_a: assert property (thermalTrip [*8] |-> selfSupply && !highSideSwitch && !lowSideSwitch)
		else $error("switching after thermal trip");
	disch_quiet_a: assert property (dischargeSwitch |-> !highSideSwitch && !lowSideSwitch)
		else $error("gate on while discharging");
	idle_quiet_a: assert property (burstIdle |-> !highSideSwitch && !lowSideSwitch)
		else $error("gate on in burst idle");
	latch_quiet_a: assert property (latchedOff |-> !highSideSwitch && !lowSideSwitch)
		else $error("gate on while latched off");
	fixed_nofault_a: assert property (fixedDeadCfg |-> !deadFault)
		else $error("dead fault in fixed mode");
	start_pulse_a: assert property (softStartReq |=> !softStartReq)
		else $error("soft start request too long");
endmodule

bind rhbd_core rhbd_core_chk rhbd_core_chk_inst
(
	.mclk(mclk), .resetn(resetn), .bootstrapUvlo(bootstrapUvlo), .thermalTrip(thermalTrip),
	.fixedDeadCfg(fixedDeadCfg), .highSideSwitch(highSideSwitch),
	.lowSideSwitch(lowSideSwitch), .dischargeSwitch(dischargeSwitch), .burstIdle(burstIdle),
	.selfSupply(selfSupply), .softStartReq(softStartReq), .latchedOff(latchedOff),
	.deadFault(deadFault)
);
`default_nettype wire

// ===== dv/rhbd_bridge_model.sv
/*
 behavioural half-bridge: midpoint swing sensing and discharge to floor.
 assumes gate commands from rhbd_core; stuckEdge models a swing that never ends.
*/
`timescale 1ns/1ps
`default_nettype none
module rhbd_bridge_model
#(
	parameter int EDGE_DLY  = 3,
	parameter int DISCH_CYC = 5
)
(
	input  wire logic mclk,
	input  wire logic highSideSwitch,
	input  wire logic lowSideSwitch,
	input  wire logic dischargeSwitch,
	input  wire logic stuckEdge,
	output logic      edgeHighToLow,
	output logic      edgeLowToHigh,
	output logic      midpointAtFloor
);
	logic lastHigh = 1'b0;
	int   gapCnt   = 0;
	int   dischCnt = 0;
	logic swingDone;

	assign swingDone = ~(highSideSwitch | lowSideSwitch) & (gapCnt >= EDGE_DLY) & ~stuckEdge;

	initial
	begin
		edgeHighToLow = 1'b0;
		edgeLowToHigh = 1'b0;
		midpointAtFloor = 1'b0;
	end

	always @(posedge mclk)
	begin
		if (highSideSwitch | lowSideSwitch)
		begin
			lastHigh <= highSideSwitch;
			gapCnt <= 0;
		end
		else
			gapCnt <= gapCnt + 1;
		// swing ends a few cycles after turn-off; a stuck swing never reports
		edgeHighToLow <= swingDone & lastHigh;
		edgeLowToHigh <= swingDone & ~lastHigh;
		// floor only reached while the discharge path pulls the midpoint
		if (highSideSwitch)
			dischCnt <= 0;
		else if (dischargeSwitch)
			dischCnt <= dischCnt + 1;
		midpointAtFloor <= dischCnt >= DISCH_CYC;
	end
endmodule
`default_nettype wire

// ===== dv/rhbd_core_tb.sv
/*
 self-checking bench for rhbd_core with the bridge model on its far side.
 assumes rhbd_pkg, the design and the checker bind are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rhbd_core_tb;
	import rhbd_pkg::*;
	typedef struct {int trip; logic entry; logic idle;} rhbd_row_type;
	rhbd_row_type   rows [3] = '{'{14, 1'b0, 1'b0}, '{10, 1'b0, 1'b0}, '{10, 1'b1, 1'b1}};
	logic           mclk, resetn, startReq, burstEntryCmp, burstExitCmp, onTimeCmp;
	logic           currentSenseTrip, bootstrapUvlo, thermalTrip, stuckEdge, faultCounterCfg;
	logic           fixedDeadCfg, edgeHighToLow, edgeLowToHigh, midpointAtFloor, frSeen;
	logic           highSideSwitch, lowSideSwitch, dischargeSwitch, burstIdle, feedbackReduce;
	logic           selfSupply, thermalMemory, softStartReq, latchedOff, deadFault, seen;
	rhbd_fault_type faultReactionCfg;
	int             errCount = 0;
	int             checks   = 0;
	int             h, l, n, p;

	rhbd_core #(.PRE_CYC(20), .DTMAX_CYC(10), .AREC_CYC(50)) rhbd_core_inst
	(
		.mclk(mclk), .resetn(resetn), .startReq(startReq), .burstEntryCmp(burstEntryCmp),
		.burstExitCmp(burstExitCmp), .onTimeCmp(onTimeCmp), .currentSenseTrip(currentSenseTrip),
		.edgeHighToLow(edgeHighToLow), .edgeLowToHigh(edgeLowToHigh),
		.midpointAtFloor(midpointAtFloor), .bootstrapUvlo(bootstrapUvlo),
		.thermalTrip(thermalTrip), .faultReactionCfg(faultReactionCfg),
		.faultCounterCfg(faultCounterCfg), .fixedDeadCfg(fixedDeadCfg),
		.highSideSwitch(highSideSwitch), .lowSideSwitch(lowSideSwitch),
		.dischargeSwitch(dischargeSwitch), .burstIdle(burstIdle), .feedbackReduce(feedbackReduce),
		.selfSupply(selfSupply), .thermalMemory(thermalMemory), .softStartReq(softStartReq),
		.latchedOff(latchedOff), .deadFault(deadFault)
	);

	rhbd_bridge_model rhbd_bridge_model_inst
	(
		.mclk(mclk), .highSideSwitch(highSideSwitch), .lowSideSwitch(lowSideSwitch),
		.dischargeSwitch(dischargeSwitch), .stuckEdge(stuckEdge), .edgeHighToLow(edgeHighToLow),
		.edgeLowToHigh(edgeLowToHigh), .midpointAtFloor(midpointAtFloor)
	);

	task automatic finishTest();
		$display("checks %0d errors %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cmpBit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			errCount++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask

	task automatic cmpInt(input int got, input int exp);
		checks++;
		if (got != exp)
		begin
			errCount++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask

	// measures one gate pulse; trip drops the on-time comparator (and current trip on high)
	task automatic pulse(input bit hi, input int trip, output int w);
		int k;
		k = 0;
		w = 0;
		while ((hi ? highSideSwitch : lowSideSwitch) !== 1'b1 && k < 2000)
		begin
			@(negedge mclk);
			k++;
		end
		while ((hi ? highSideSwitch : lowSideSwitch) === 1'b1 && w < 2000)
		begin
			if (w == trip)
			begin
				currentSenseTrip = hi;
				onTimeCmp = 1'b0;
			end
			if (w == 1)
				frSeen = feedbackReduce;
			@(negedge mclk);
			w++;
		end
		currentSenseTrip = 1'b0;
		onTimeCmp = 1'b1;
		// a pulse that never starts or never ends is a mismatch
		if (k >= 2000 || w >= 2000)
			errCount++;
	endtask

	task automatic restart(input rhbd_fault_type cfg, input logic stuck, input logic fixed);
		resetn = 1'b0;
		faultReactionCfg = cfg;
		stuckEdge = stuck;
		fixedDeadCfg = fixed;
		repeat (2) @(negedge mclk);
		resetn = 1'b1;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// whole run needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		errCount++;
		finishTest();
	end

	initial
	begin
		{startReq, burstEntryCmp, burstExitCmp, currentSenseTrip, bootstrapUvlo} = '0;
		{thermalTrip, faultCounterCfg} = '0;
		onTimeCmp = 1'b1;
		restart(RHBD_FLT_IGNORE, 1'b0, 1'b0);
		@(negedge mclk);
		cmpBit(highSideSwitch | lowSideSwitch | dischargeSwitch, 1'b0);
		startReq = 1'b1;
		foreach (rows[i])
		begin
			burstEntryCmp = rows[i].entry;
			pulse(1'b1, rows[i].trip, h);
			pulse(1'b0, 0, l);
			burstEntryCmp = 1'b0;
			cmpInt(l, rows[i].entry ? h + h / 2 : h);
			repeat (4) @(negedge mclk);
			cmpBit(burstIdle, rows[i].idle);
		end
		burstExitCmp = 1'b1;
		pulse(1'b0, 0, l);
		cmpInt(l, 20);
		pulse(1'b1, 8, h);
		burstExitCmp = 1'b0;
		cmpBit(frSeen, 1'b1);
		pulse(1'b0, h + 6, l);
		cmpBit(l > h, 1'b1);
		p = h;
		burstEntryCmp = 1'b1;
		pulse(1'b1, 40, h);
		pulse(1'b0, 40, l);
		burstEntryCmp = 1'b0;
		cmpInt(h, p);
		cmpInt(l, h + h / 2);
		startReq = 1'b0;
		thermalTrip = 1'b1;
		bootstrapUvlo = 1'b1;
		repeat (10) @(negedge mclk);
		cmpBit(highSideSwitch | lowSideSwitch, 1'b0);
		cmpBit(selfSupply & thermalMemory, 1'b1);
		thermalTrip = 1'b0;
		bootstrapUvlo = 1'b0;
		repeat (10) @(negedge mclk);
		startReq = 1'b1;
		seen = 1'b0;
		for (n = 0; n < 400 && !seen; n++)
		begin
			@(negedge mclk);
			seen = softStartReq;
		end
		cmpBit(seen, 1'b1);
		restart(RHBD_FLT_LATCH, 1'b1, 1'b0);
		for (n = 0; n < 400 && latchedOff !== 1'b1; n++)
			@(negedge mclk);
		cmpBit(latchedOff, 1'b1);
		cmpBit(deadFault, 1'b1);
		faultCounterCfg = 1'b1;
		restart(RHBD_FLT_AREC, 1'b1, 1'b0);
		pulse(1'b1, 40, h);
		cmpBit(deadFault, 1'b0);
		for (n = 0; n < 400 && deadFault !== 1'b1; n++)
			@(negedge mclk);
		@(negedge mclk);
		cmpBit(deadFault & selfSupply & ~latchedOff, 1'b1);
		for (n = 0; n < 400 && dischargeSwitch !== 1'b1; n++)
			@(negedge mclk);
		cmpBit(dischargeSwitch & ~deadFault, 1'b1);
		faultCounterCfg = 1'b0;
		restart(RHBD_FLT_LATCH, 1'b1, 1'b1);
		pulse(1'b1, 6, h);
		pulse(1'b0, 0, l);
		cmpBit(l > 0, 1'b1);
		cmpBit(latchedOff | deadFault, 1'b0);
		finishTest();
	end
endmodule
`default_nettype wire
